// *** src/tci_top.sv ***
// reader-side stream protection: crc append or inverted repeat
`timescale 1ns/1ps
`include "tci_map.svh"
module tci_top (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic CE,
	input wire tci_pkg::tci_family_e FAMILY_SEL,
	input wire logic CRYPTO_EN,
	input wire logic KEY_BIT,
	input wire logic START,
	input wire logic [8:0] LEN,
	input wire logic IN_BIT,
	output logic IN_TAKE,
	output logic TX_VALID,
	output logic TX_BIT,
	output logic TX_LAST,
	output logic BUSY,
	output tci_pkg::tci_family_e RX_MODE
);
	import tci_pkg::*;
	// ****************************************
	// state
	// ****************************************
	tci_state_e state_q, state_d;
	logic [8:0] cnt_q, cnt_d;
	logic [8:0] len_q;
	tci_family_e fam_q;
	logic crypto_q;
	logic [255:0] cmd_q;
	logic [7:0] crc;
	wire crc_preset = SRST | (state_q == ST_IDLE);
	wire crc_shift = (state_q == ST_PAY) & (fam_q == FAM_ONE);
	wire last_cnt = (cnt_q == len_q - 9'd1);
	wire [7:0] crc_idx = 8'(`TCI_CRC_W - 1) - 8'(cnt_q);
	wire crc_bit = crc[crc_idx[2:0]];
	wire inv_bit = ~cmd_q[cnt_q[7:0]];
	wire ks = crypto_q & KEY_BIT;
	// receive mode moves together with the latched family so it is settled from the first busy cycle
	wire tci_family_e mode_next = (state_q == ST_IDLE) ? FAMILY_SEL : fam_q;
	tci_crc8 u_crc (
		.CLK(CLK),
		.ce(CE),
		.preset(crc_preset),
		.shift(crc_shift),
		.din(IN_BIT),
		.crc(crc)
	);
	// ****************************************
	// sequencing
	// ****************************************
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			ST_IDLE: begin
				cnt_d = 9'h000;
				if (START && LEN != 9'h000) begin
					state_d = ST_PAY;
				end
			end
			ST_PAY: begin
				cnt_d = cnt_q + 9'd1;
				if (last_cnt) begin
					cnt_d = 9'h000;
					state_d = (fam_q == FAM_ONE) ? ST_CRC : ST_INV_WAIT;
				end
			end
			ST_CRC: begin
				cnt_d = cnt_q + 9'd1;
				if (cnt_q == 9'(`TCI_CRC_W - 1)) begin
					state_d = ST_IDLE;
				end
			end
			ST_INV_WAIT: begin
				state_d = ST_INV;
			end
			ST_INV: begin
				cnt_d = cnt_q + 9'd1;
				if (last_cnt) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q <= ST_IDLE;
			cnt_q <= 9'h000;
			len_q <= 9'h001;
			fam_q <= FAM_ONE;
			crypto_q <= 1'b0;
			RX_MODE <= FAM_ONE;
		end else if (CE) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			RX_MODE <= mode_next;
			if (state_q == ST_IDLE) begin
				fam_q <= FAMILY_SEL;
				crypto_q <= CRYPTO_EN;
				if (START) begin
					len_q <= (FAMILY_SEL == FAM_TWO && LEN > 9'd256) ? 9'd256 : LEN;
				end
			end
		end
	end
	// ****************************************
	// output bit path
	// ****************************************
	always_ff @(posedge CLK) begin
		if (SRST) begin
			TX_VALID <= 1'b0;
			TX_BIT <= 1'b0;
			TX_LAST <= 1'b0;
			IN_TAKE <= 1'b0;
			BUSY <= 1'b0;
		end else if (CE) begin
			BUSY <= (state_d != ST_IDLE);
			IN_TAKE <= 1'b0;
			TX_VALID <= 1'b0;
			TX_LAST <= 1'b0;
			unique case (state_q)
				ST_PAY: begin
					IN_TAKE <= 1'b1;
					TX_VALID <= 1'b1;
					TX_BIT <= IN_BIT ^ ks;
					cmd_q[cnt_q[7:0]] <= IN_BIT;
				end
				ST_CRC: begin
					TX_VALID <= 1'b1;
					TX_BIT <= crc_bit ^ ks;
					TX_LAST <= (cnt_q == 9'(`TCI_CRC_W - 1));
				end
				ST_INV: begin
					TX_VALID <= 1'b1;
					TX_BIT <= inv_bit ^ ks;
					TX_LAST <= last_cnt;
				end
				default: begin
				end
			endcase
		end
	end
endmodule : tci_top

// *** src/tci_map.svh ***
// constants of the transponder command integrity block
// Notes on behaviour
// - In first-family mode every outgoing command, address or data stream gets a check value appended.
// - The check value is eight bits, polynomial x^8+x^4+x^3+x^2+1 (0x1D).
// - The check register is preset to 0xFF before the first bit of each stream.
// - The check covers the command and address fields or the plain data, whichever the stream holds.
// - In crypto mode the check value is passed through the keystream together with the payload.
// - In second-family mode each command is sent twice, the second copy bit-inverted; commands longer than 256 bits are cut to their first 256.
// - The family scheme and matching receive mode follow the software selection.
`ifndef TCI_MAP_SVH
`define TCI_MAP_SVH
`define TCI_CRC_POLY 8'h1D
`define TCI_CRC_PRESET 8'hFF
`define TCI_CRC_W 8
`define TCI_CNT_W 9
`endif

// *** src/tci_pkg.sv ***
// types of the transponder command integrity block
package tci_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PAY = 3'b001,
		ST_CRC = 3'b010,
		ST_INV_WAIT = 3'b011,
		ST_INV = 3'b100
	} tci_state_e;
	typedef enum logic {
		FAM_ONE = 1'b0,
		FAM_TWO = 1'b1
	} tci_family_e;
endpackage : tci_pkg

// *** src/tci_crc8.sv ***
// serial crc-8 generator, msb first
`timescale 1ns/1ps
`include "tci_map.svh"
module tci_crc8 (
	input wire logic CLK,
	input wire logic ce,
	input wire logic preset,
	input wire logic shift,
	input wire logic din,
	output logic [7:0] crc
);
	logic [7:0] crc_d;
	wire fb = crc[7] ^ din;
	assign crc_d = {crc[6:0], 1'b0} ^ (fb ? `TCI_CRC_POLY : 8'h00);
	always_ff @(posedge CLK) begin
		if (ce) begin
			if (preset) begin
				crc <= `TCI_CRC_PRESET;
			end else if (shift) begin
				crc <= crc_d;
			end
		end
	end
endmodule : tci_crc8

// *** tb/tci_top_properties.sv ***
// checker: port timing of the integrity block
`timescale 1ns/1ps
module tci_top_properties
	import tci_pkg::*;
	(input wire logic CLK, SRST, CE, START, IN_TAKE, TX_VALID, TX_LAST, BUSY,
	input wire logic [8:0] LEN, input wire tci_pkg::tci_family_e FAMILY_SEL, RX_MODE);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	sequence s_crc; (TX_VALID && !TX_LAST) [*8]; endsequence
	sequence s_gap; !TX_VALID ##1 TX_VALID; endsequence
	property p_take; START && CE && !BUSY && LEN != 9'h000 |-> ##[1:3] TX_VALID; endproperty
	a_take: assert property (p_take) else $error("no output");
	property p_zero; START && !BUSY && LEN == 9'h000 |=> !BUSY; endproperty
	a_zero: assert property (p_zero) else $error("empty start");
	property p_crc; $rose(TX_VALID) && RX_MODE == FAM_ONE |-> s_crc; endproperty
	a_crc: assert property (p_crc) else $error("short stream");
	property p_gap; $fell(TX_VALID) && !$past(TX_LAST) && RX_MODE == FAM_TWO |-> s_gap; endproperty
	a_gap: assert property (p_gap) else $error("bad gap");
	property p_mode; BUSY && $past(BUSY) |-> $stable(RX_MODE); endproperty
	a_mode: assert property (p_mode) else $error("mode moved");
	property p_sel; $rose(BUSY) |-> RX_MODE == $past(FAMILY_SEL); endproperty
	a_sel: assert property (p_sel) else $error("wrong mode");
	property p_end; TX_LAST |-> TX_VALID ##1 !TX_VALID; endproperty
	a_end: assert property (p_end) else $error("bad end");
	property p_use; IN_TAKE |-> TX_VALID; endproperty
	a_use: assert property (p_use) else $error("lost bit");
endmodule : tci_top_properties
bind tci_top tci_top_properties u_props(.*);

// *** tb/tci_tag.sv ***
// transponder model: decrypts and crc-checks streams
`timescale 1ns/1ps
module tci_tag(input wire logic CLK, TX_VALID, TX_BIT, TX_LAST, KEY,
	output logic [527:0] p, output logic [7:0] c, output int n);
	logic kq = 0, f = 1;
	wire b = TX_BIT ^ kq;
	wire [7:0] s = f ? 8'hFF : c;
	always_ff @(posedge CLK) begin
		kq <= KEY;
		if (TX_VALID) begin
			p <= {p[526:0], b};
			c <= {s[6:0], 1'b0} ^ ((s[7] ^ b) ? 8'h1D : 8'h00);
			n <= f ? 1 : n + 1;
			f <= TX_LAST;
		end
	end
endmodule : tci_tag

// *** tb/tb_top.sv ***
// bench: random and corner streams through the block
`timescale 1ns/1ps
module tb_top;
	import tci_pkg::*;
	logic CLK = 0, SRST = 1, CE = 1, CRYPTO_EN = 0, KEY_BIT = 0, START = 0, IN_BIT = 0;
	logic IN_TAKE, TX_VALID, TX_BIT, TX_LAST, BUSY;
	logic [8:0] LEN = 9'h001;
	tci_family_e FAMILY_SEL = FAM_ONE, RX_MODE;
	logic [527:0] v, p, m;
	logic [7:0] c;
	int n, fail_count = 0, n_checks = 0;
	tci_top dut(.*);
	tci_tag tag(.CLK, .TX_VALID, .TX_BIT, .TX_LAST, .KEY(KEY_BIT & CRYPTO_EN), .p, .c, .n);
	always #12.5 CLK = ~CLK;
	always @(posedge CLK) #1 KEY_BIT <= 1'($urandom);
	task chk(string s, logic [527:0] a, e);
		n_checks++;
		if (a !== e) begin
			fail_count++;
			$display("unexpected %s exp %0h got %0h", s, e, a);
		end
	endtask : chk
	function automatic logic [7:0] crc(int l);
		logic [7:0] r = 8'hFF;
		for (int i = l - 1; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ v[i]) ? 8'h1D : 8'h00);
		return r;
	endfunction : crc
	task run(tci_family_e f, logic k, int l);
		for (int i = 0; i < 528; i++) v[i] = 1'($urandom);
		m = (528'h1 << l) - 1;
		@(posedge CLK) #1;
		FAMILY_SEL = f;
		CRYPTO_EN = k;
		LEN = 9'(l);
		START = 1;
		IN_BIT = v[l-1];
		@(posedge CLK) #1 START = 0;
		for (int i = l - 2; i >= 0; i--) @(posedge CLK) #1 IN_BIT = v[i];
		for (int t = 0; t < 600 && TX_LAST !== 1'b1; t++) @(posedge CLK) #1;
		chk("last", TX_LAST, 1);
		@(posedge CLK) #1;
		chk("mode", RX_MODE, f);
		if (f == FAM_ONE) begin
			chk("len", n, l + 8);
			chk("data", (p >> 8) & m, v & m);
			chk("crc", p[7:0], crc(l));
			chk("rem", c, 0);
		end else begin
			chk("len", n, 2 * l);
			chk("data", (p >> l) & m, v & m);
			chk("inv", p & m, ~v & m);
		end
	endtask : run
	task summarize();
		if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	initial begin
		#1000000;
		fail_count++;
		summarize();
	end
	initial begin
		void'($urandom(9));
		repeat (3) @(posedge CLK);
		#1 SRST = 0;
		LEN = 9'h000;
		START = 1;
		@(posedge CLK) #1 START = 0;
		@(posedge CLK) #1;
		chk("busy", BUSY, 0);
		run(FAM_ONE, 0, 1);
		run(FAM_TWO, 0, 256);
		run(FAM_ONE, 1, 256);
		run(FAM_TWO, 1, 1);
		repeat (30) run(tci_family_e'($urandom % 2), 1'($urandom), 1 + $urandom % 64);
		summarize();
	end
endmodule : tb_top
